// ===== logic/flash_bus_engine.sv
// Pin engine: runs one timed write or read cycle on the flash pins
`timescale 1ns/1ps
module flash_bus_engine (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   flash_bus_if.engine      bus,
   input  wire logic [15:0] i_dq,
   output logic      [25:0] o_addr,
   output logic      [15:0] o_dq,
   output logic             o_dq_oe,
   output logic             o_ce_n,
   output logic             o_we_n,
   output logic             o_oe_n
);
   typedef enum logic [4:0] {
      E_IDLE = 5'h01, E_SETUP = 5'h02, E_STROBE = 5'h04, E_READ = 5'h08, E_RECOV = 5'h10
   } eng_t;
   eng_t        state_q;
   logic [3:0]  cnt_q;
   logic        done_q;
   logic [15:0] rdata_q;

   assign bus.done  = done_q;
   assign bus.rdata = rdata_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= E_IDLE;
         cnt_q   <= 4'h0;
         done_q  <= 1'b0;
         rdata_q <= 16'h0000;
         o_addr  <= 26'h0;
         o_dq    <= 16'h0000;
         o_dq_oe <= 1'b0;
         o_ce_n  <= 1'b1;
         o_we_n  <= 1'b1;
         o_oe_n  <= 1'b1;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            E_IDLE: begin
               if (bus.req) begin
                  o_addr <= bus.addr;
                  o_ce_n <= 1'b0;
                  if (bus.wr) begin
                     o_dq    <= bus.data;
                     o_dq_oe <= 1'b1;
                     state_q <= E_SETUP;
                  end else begin
                     o_oe_n  <= 1'b0;
                     cnt_q   <= flash_host_pkg::RD_CYC - 4'h1;
                     state_q <= E_READ;
                  end
               end
            end
            // Address and data settle before the strobe falls
            E_SETUP: begin
               o_we_n  <= 1'b0;
               cnt_q   <= flash_host_pkg::WP_CYC - 4'h1;
               state_q <= E_STROBE;
            end
            E_STROBE: begin
               if (cnt_q == 4'h0) begin
                  o_we_n  <= 1'b1;
                  o_ce_n  <= 1'b1;
                  cnt_q   <= flash_host_pkg::WPH_CYC - 4'h1;
                  state_q <= E_RECOV;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            E_READ: begin
               if (cnt_q == 4'h0) begin
                  rdata_q <= i_dq;
                  o_oe_n  <= 1'b1;
                  o_ce_n  <= 1'b1;
                  cnt_q   <= flash_host_pkg::WPH_CYC - 4'h1;
                  state_q <= E_RECOV;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            // Data stays driven past the rising strobe, then released
            E_RECOV: begin
               if (cnt_q == 4'h0) begin
                  o_dq_oe <= 1'b0;
                  done_q  <= 1'b1;
                  state_q <= E_IDLE;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            default: state_q <= E_IDLE;
         endcase
      end
   end

   a_strobe_width: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $fell(o_we_n) |-> !o_we_n [*4] ##1 o_we_n)
      else $error("write strobe width wrong");
   a_write_stable: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !o_we_n |-> !o_ce_n && o_dq_oe && $stable(o_addr) && $stable(o_dq))
      else $error("address or data moved during strobe");
   a_data_past_rise: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(o_we_n) |-> o_dq_oe && $stable(o_dq))
      else $error("data dropped at strobe rise");
endmodule

// ===== logic/flash_bus_if.sv
// One flash bus cycle request between sequencer and pin engine
`timescale 1ns/1ps
interface flash_bus_if;
   logic        req;
   logic        wr;
   logic [25:0] addr;
   logic [15:0] data;
   logic        done;
   logic [15:0] rdata;
   modport master (output req, output wr, output addr, output data,
                   input done, input rdata);
   modport engine (input req, input wr, input addr, input data,
                   output done, output rdata);
endinterface

// ===== logic/flash_host_pkg.sv
// Constants, types and step decoding shared by the flash host sequencer
package flash_host_pkg;
   localparam int ADDR_W   = 26;
   localparam int DATA_W   = 16;
   localparam int SECT_LSB = 16;
   localparam int PAGE_LSB = 5;
   localparam int CLK_NS   = 10;
   localparam int T_WP_NS  = 35;
   localparam int T_WPH_NS = 30;
   localparam int T_RD_NS  = 110;
   localparam logic [3:0] WP_CYC  = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] WPH_CYC = 4'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] RD_CYC  = 4'((T_RD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [11:0] A_U1  = 12'h555;
   localparam logic [11:0] A_U2  = 12'h2AA;
   localparam logic [11:0] A_CFI = 12'h055;
   localparam logic [11:0] A_ANY = 12'h000;
   localparam logic [7:0] D_U1   = 8'hAA;
   localparam logic [7:0] D_U2   = 8'h55;
   localparam logic [7:0] D_RST  = 8'hF0;
   localparam logic [7:0] D_AUTO = 8'h90;
   localparam logic [7:0] D_CFI  = 8'h98;
   localparam logic [7:0] D_PROG = 8'hA0;
   localparam logic [7:0] D_BUF  = 8'h25;
   localparam logic [7:0] D_CONF = 8'h29;
   localparam logic [7:0] D_BYP  = 8'h20;
   localparam logic [7:0] D_ERS  = 8'h80;
   localparam logic [7:0] D_CHIP = 8'h10;
   localparam logic [7:0] D_S30  = 8'h30;
   localparam logic [7:0] D_SUSP = 8'hB0;
   localparam logic [7:0] D_SECS = 8'h88;
   localparam logic [7:0] D_ZERO = 8'h00;

   typedef enum logic [4:0] {
      C_READ, C_RESET, C_AUTOSEL, C_CFI, C_PROG, C_BUF_START, C_BUF_WORD,
      C_BUF_CONFIRM, C_ABORT_RST, C_BYP_ENTER, C_BYP_PROG, C_BYP_SERASE,
      C_BYP_CERASE, C_BYP_EXIT, C_CERASE, C_SERASE, C_SUSPEND, C_RESUME,
      C_SEC_ENTRY, C_SEC_EXIT
   } cmd_t;
   typedef enum logic [1:0] {SRC_FIX, SRC_SECT, SRC_USER, SRC_CNT} src_t;
   typedef struct packed {
      src_t        src;
      logic [11:0] addr;
      logic [7:0]  data;
      logic        last;
   } step_t;

   function automatic logic unlocks(cmd_t op);
      return op inside {C_AUTOSEL, C_PROG, C_BUF_START, C_ABORT_RST, C_BYP_ENTER,
                        C_CERASE, C_SERASE, C_SEC_ENTRY, C_SEC_EXIT};
   endfunction

   // Bus cycle i of command op
   function automatic step_t step_of(cmd_t op, logic [2:0] i);
      step_t      s;
      logic [2:0] j;
      s = '{SRC_FIX, A_ANY, D_ZERO, 1'b1};
      j = i - 3'h2;
      if (unlocks(op) && i == 3'h0) s = '{SRC_FIX, A_U1, D_U1, 1'b0};
      else if (unlocks(op) && i == 3'h1) s = '{SRC_FIX, A_U2, D_U2, 1'b0};
      else begin
         case (op)
            C_READ, C_BUF_WORD: s.src = SRC_USER;
            C_RESET:       s.data = D_RST;
            C_CFI:         s = '{SRC_FIX, A_CFI, D_CFI, 1'b1};
            C_AUTOSEL:     s = '{SRC_FIX, A_U1, D_AUTO, 1'b1};
            C_PROG:        s = (j == 3'h0) ? step_t'{SRC_FIX, A_U1, D_PROG, 1'b0}
                                           : step_t'{SRC_USER, A_ANY, D_ZERO, 1'b1};
            C_BUF_START:   s = (j == 3'h0) ? step_t'{SRC_SECT, A_ANY, D_BUF, 1'b0}
                                           : step_t'{SRC_CNT, A_ANY, D_ZERO, 1'b1};
            C_BUF_CONFIRM: s = '{SRC_SECT, A_ANY, D_CONF, 1'b1};
            C_ABORT_RST:   s = '{SRC_FIX, A_U1, D_RST, 1'b1};
            C_BYP_ENTER:   s = '{SRC_FIX, A_U1, D_BYP, 1'b1};
            C_BYP_PROG:    s = (i == 3'h0) ? step_t'{SRC_FIX, A_ANY, D_PROG, 1'b0}
                                           : step_t'{SRC_USER, A_ANY, D_ZERO, 1'b1};
            C_BYP_SERASE:  s = (i == 3'h0) ? step_t'{SRC_FIX, A_ANY, D_ERS, 1'b0}
                                           : step_t'{SRC_SECT, A_ANY, D_S30, 1'b1};
            C_BYP_CERASE:  s = (i == 3'h0) ? step_t'{SRC_FIX, A_ANY, D_ERS, 1'b0}
                                           : step_t'{SRC_FIX, A_ANY, D_CHIP, 1'b1};
            C_BYP_EXIT:    s = (i == 3'h0) ? step_t'{SRC_FIX, A_ANY, D_AUTO, 1'b0}
                                           : step_t'{SRC_FIX, A_ANY, D_ZERO, 1'b1};
            C_CERASE, C_SERASE: begin
               case (j)
                  3'h0: s = '{SRC_FIX, A_U1, D_ERS, 1'b0};
                  3'h1: s = '{SRC_FIX, A_U1, D_U1, 1'b0};
                  3'h2: s = '{SRC_FIX, A_U2, D_U2, 1'b0};
                  default: s = (op == C_CERASE) ? step_t'{SRC_FIX, A_U1, D_CHIP, 1'b1}
                                                : step_t'{SRC_SECT, A_ANY, D_S30, 1'b1};
               endcase
            end
            C_SUSPEND:     s.data = D_SUSP;
            C_RESUME:      s.data = D_S30;
            C_SEC_ENTRY:   s = '{SRC_FIX, A_U1, D_SECS, 1'b1};
            C_SEC_EXIT:    s = (j == 3'h0) ? step_t'{SRC_FIX, A_U1, D_AUTO, 1'b0}
                                           : step_t'{SRC_FIX, A_ANY, D_ZERO, 1'b1};
            default: s.last = 1'b1;
         endcase
      end
      return s;
   endfunction
endpackage

// ===== logic/flash_host_sequencer.sv
// Host sequencer issuing NOR flash command sequences over the pins
`timescale 1ns/1ps
module flash_host_sequencer (
   input  wire logic                 I_CLK,
   input  wire logic                 I_RESET_N,
   input  wire logic                 I_CMD_VALID,
   input  wire flash_host_pkg::cmd_t I_CMD_OP,
   input  wire logic          [25:0] I_CMD_ADDR,
   input  wire logic          [15:0] I_CMD_DATA,
   input  wire logic           [4:0] I_CMD_COUNT,
   output logic                      O_CMD_READY,
   output logic                      O_CMD_ERR,
   output logic                      O_RD_VALID,
   output logic               [15:0] O_RD_DATA,
   output logic                      O_BYPASS,
   output logic               [25:0] O_ADDR,
   output logic               [15:0] O_DQ,
   output logic                      O_DQ_OE,
   input  wire logic          [15:0] I_DQ,
   output logic                      O_CE_N,
   output logic                      O_WE_N,
   output logic                      O_OE_N
);
   typedef enum logic [2:0] {S_IDLE = 3'h1, S_ISSUE = 3'h2, S_WAIT = 3'h4} seq_t;

   logic                  sync1_q;
   logic                  rst_n;
   seq_t                  state_q;
   flash_host_pkg::cmd_t  op_q;
   logic [25:0]           addr_q;
   logic [15:0]           data_q;
   logic [4:0]            cnt_q;
   logic [2:0]            idx_q;
   logic                  bypass_q;
   logic                  autosel_q;
   logic                  buf_on_q;
   logic                  buf_first_q;
   logic [5:0]            buf_left_q;
   logic [20:0]           buf_page_q;
   logic                  take;
   logic                  legal;
   logic                  finish;
   flash_host_pkg::step_t st;

   flash_bus_if bif ();

   flash_bus_engine u_engine (
      .i_clk   (I_CLK),
      .i_rst_n (rst_n),
      .bus     (bif.engine),
      .i_dq    (I_DQ),
      .o_addr  (O_ADDR),
      .o_dq    (O_DQ),
      .o_dq_oe (O_DQ_OE),
      .o_ce_n  (O_CE_N),
      .o_we_n  (O_WE_N),
      .o_oe_n  (O_OE_N)
   );

   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         sync1_q <= 1'b0;
         rst_n   <= 1'b0;
      end else begin
         sync1_q <= 1'b1;
         rst_n   <= sync1_q;
      end
   end

   assign take   = O_CMD_READY && I_CMD_VALID;
   assign st     = flash_host_pkg::step_of(op_q, idx_q);
   assign finish = state_q == S_WAIT && bif.done && st.last;

   // Refuse commands the present mode cannot accept
   always_comb begin
      legal = 1'b1;
      case (I_CMD_OP)
         flash_host_pkg::C_CFI: legal = !bypass_q && !buf_on_q;
         flash_host_pkg::C_BYP_PROG, flash_host_pkg::C_BYP_SERASE,
         flash_host_pkg::C_BYP_CERASE, flash_host_pkg::C_BYP_EXIT:
            legal = bypass_q;
         flash_host_pkg::C_BUF_WORD:
            legal = buf_on_q && buf_left_q != 6'h00 &&
                    (buf_first_q || I_CMD_ADDR[25:5] == buf_page_q);
         flash_host_pkg::C_BUF_CONFIRM: legal = buf_on_q && buf_left_q == 6'h00;
         default: legal = 1'b1;
      endcase
   end

   // Build the cycle for the current step
   assign bif.req = state_q == S_ISSUE;
   assign bif.wr  = op_q != flash_host_pkg::C_READ;
   always_comb begin
      case (st.src)
         flash_host_pkg::SRC_USER: begin
            bif.addr = addr_q;
            bif.data = data_q;
         end
         flash_host_pkg::SRC_SECT: begin
            bif.addr = {addr_q[25:16], 16'h0000};
            bif.data = {8'h00, st.data};
         end
         flash_host_pkg::SRC_CNT: begin
            bif.addr = {addr_q[25:16], 16'h0000};
            bif.data = {11'h000, cnt_q};
         end
         default: begin
            bif.addr = {14'h0000, st.addr};
            bif.data = {8'h00, st.data};
         end
      endcase
   end

   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_q     <= S_IDLE;
         O_CMD_READY <= 1'b1;
         op_q        <= flash_host_pkg::C_READ;
         addr_q      <= 26'h0;
         data_q      <= 16'h0000;
         cnt_q       <= 5'h00;
         idx_q       <= 3'h0;
      end else begin
         case (state_q)
            S_IDLE: begin
               if (take && legal) begin
                  op_q        <= I_CMD_OP;
                  addr_q      <= I_CMD_ADDR;
                  data_q      <= I_CMD_DATA;
                  cnt_q       <= I_CMD_COUNT;
                  idx_q       <= 3'h0;
                  O_CMD_READY <= 1'b0;
                  state_q     <= S_ISSUE;
               end
            end
            S_ISSUE: state_q <= S_WAIT;
            S_WAIT: begin
               if (finish) begin
                  O_CMD_READY <= 1'b1;
                  state_q     <= S_IDLE;
               end else if (bif.done) begin
                  idx_q   <= idx_q + 3'h1;
                  state_q <= S_ISSUE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         O_CMD_ERR  <= 1'b0;
         O_RD_VALID <= 1'b0;
         O_RD_DATA  <= 16'h0000;
      end else begin
         O_CMD_ERR  <= take && !legal;
         O_RD_VALID <= finish && op_q == flash_host_pkg::C_READ;
         if (finish && op_q == flash_host_pkg::C_READ) begin
            O_RD_DATA <= bif.rdata;
         end
      end
   end

   // Track device mode from completed sequences
   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         bypass_q    <= 1'b0;
         autosel_q   <= 1'b0;
         buf_on_q    <= 1'b0;
         buf_first_q <= 1'b0;
         buf_left_q  <= 6'h00;
         buf_page_q  <= 21'h0;
      end else if (finish) begin
         case (op_q)
            flash_host_pkg::C_RESET: begin
               autosel_q <= 1'b0;
               buf_on_q  <= 1'b0;
            end
            flash_host_pkg::C_AUTOSEL: autosel_q <= 1'b1;
            flash_host_pkg::C_BYP_ENTER: bypass_q <= 1'b1;
            flash_host_pkg::C_BYP_EXIT: bypass_q <= 1'b0;
            flash_host_pkg::C_SEC_EXIT: autosel_q <= 1'b0;
            flash_host_pkg::C_ABORT_RST, flash_host_pkg::C_BUF_CONFIRM:
               buf_on_q <= 1'b0;
            flash_host_pkg::C_BUF_START: begin
               buf_on_q    <= 1'b1;
               buf_first_q <= 1'b1;
               buf_left_q  <= {1'b0, cnt_q} + 6'h01;
            end
            flash_host_pkg::C_BUF_WORD: begin
               buf_first_q <= 1'b0;
               buf_page_q  <= addr_q[25:5];
               buf_left_q  <= buf_left_q - 6'h01;
            end
            default: buf_first_q <= buf_first_q;
         endcase
      end
   end

   assign O_BYPASS = bypass_q;

   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!rst_n);

   sequence s_unlock;
      bif.req && bif.addr == 26'h555 && bif.data == 16'h00AA
      ##[1:20] bif.req && bif.addr == 26'h2AA && bif.data == 16'h0055;
   endsequence

   a_unlock_lead: assert property (
      take && legal && flash_host_pkg::unlocks(I_CMD_OP) |=> s_unlock)
      else $error("unlock pair missing");
   a_abort_full: assert property (
      take && legal && I_CMD_OP == flash_host_pkg::C_ABORT_RST
      |=> s_unlock ##[1:20] bif.req && bif.data == 16'h00F0)
      else $error("abort recovery not full sequence");
   a_reset_code: assert property (
      take && I_CMD_OP == flash_host_pkg::C_RESET |=> bif.req && bif.data == 16'h00F0)
      else $error("reset write wrong");
   a_cfi_gate: assert property (
      take && I_CMD_OP == flash_host_pkg::C_CFI && (bypass_q || buf_on_q)
      |=> O_CMD_ERR && O_CMD_READY)
      else $error("query accepted outside allowed modes");
   a_upper_clean: assert property (
      bif.req && st.src == flash_host_pkg::SRC_FIX
      |-> bif.data[15:8] == 8'h00 && bif.addr[25:12] == 14'h0000)
      else $error("command cycle has upper bits set");
   a_page_keep: assert property (
      finish && op_q == flash_host_pkg::C_BUF_WORD && !buf_first_q
      |-> addr_q[25:5] == buf_page_q)
      else $error("buffer word outside page");
   a_count_word: assert property (
      bif.req && st.src == flash_host_pkg::SRC_CNT
      |-> idx_q == 3'h3 && bif.addr[15:0] == 16'h0000 && bif.data == {11'h000, cnt_q})
      else $error("word count cycle wrong");
   a_bypass_exit: assert property (
      finish && op_q == flash_host_pkg::C_BYP_EXIT |=> !bypass_q && O_CMD_READY)
      else $error("bypass not left");
   a_read_answer: assert property (
      bif.req && !bif.wr |-> ##[14:20] O_RD_VALID)
      else $error("read answer late");
endmodule

// ===== verif/flash_dev_model.sv
// Behavioural NOR flash device on the far side of the host pins
`timescale 1ns/1ps
module flash_dev_model #(
   parameter logic [15:0] MFR_ID  = 16'h00C3,  // Arbitrary identity value
   parameter logic [15:0] DEV_ID  = 16'h3C00,  // Arbitrary identity value
   parameter logic        PROT    = 1'b1,
   parameter logic        SEC_LCK = 1'b1
) (
   input  wire logic [25:0] i_addr,
   input  wire logic [15:0] i_dq,
   input  wire logic        i_ce_n,
   input  wire logic        i_we_n,
   input  wire logic        i_oe_n,
   output logic      [15:0] o_dq
);
   logic [15:0] mem [0:255];
   logic [25:0] wa [$];
   logic [15:0] wd [$];
   logic [25:0] a_q;
   logic [15:0] v;
   logic [1:0]  ust;
   logic        auto_q, byp, bx, prg, armed;
   wire logic       wr_n = i_ce_n | i_we_n;
   wire logic [7:0] off  = i_addr[7:0];
   wire logic [7:0] d    = i_dq[7:0];
   initial begin
      foreach (mem[k]) mem[k] = 16'hFFFF;
      {ust, auto_q, byp, bx, prg, armed} = '0;
   end
   // Address on the later falling strobe, data on the earlier rising one
   always @(negedge wr_n) begin
      a_q   = i_addr;
      armed = 1'b1;
   end
   // The power-up rise of the strobes is not a write
   always @(posedge wr_n) if (armed) begin
      wa.push_back(a_q);
      wd.push_back(i_dq);
      if (prg) begin
         mem[a_q[7:0]] = i_dq;
         prg = 1'b0;
      end else if (byp) begin
         if (d == 8'hA0) prg = 1'b1;
         if (bx && d == 8'h00) byp = 1'b0;
         bx = (d == 8'h90);
      end else if (d == 8'hF0) auto_q = 1'b0;
      else if (auto_q && d == 8'h00) auto_q = 1'b0;
      else if (ust == 2'h2 && a_q[11:0] == 12'h555) begin
         if (d == 8'h90) auto_q = 1'b1;
         if (d == 8'h20) byp = 1'b1;
         if (d == 8'hA0) prg = 1'b1;
      end
      if (a_q[11:0] == 12'h555 && d == 8'hAA) ust = 2'h1;
      else if (ust == 2'h1 && a_q[11:0] == 12'h2AA && d == 8'h55) ust = 2'h2;
      else ust = 2'h0;
   end
   // Unselected lines show the inverse of the addressed word, never the word itself
   always @* begin
      v = mem[off];
      if (auto_q) begin
         case (off)
            8'h00:   v = MFR_ID;
            8'h02:   v = {15'h0000, PROT};
            8'h03:   v = {8'h00, SEC_LCK, 7'h00};
            default: v = DEV_ID + {8'h00, off};
         endcase
      end
      if (!i_ce_n && !i_oe_n) o_dq = v;
      else o_dq = ~v;
   end
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the flash host sequencer against the device model
`timescale 1ns/1ps
module tb_top;
   `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
      $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
   localparam logic [15:0] MFR = 16'h00C3;
   localparam logic [15:0] DEV = 16'h3C00;
   localparam logic [25:0] SEC = 26'h2341234;
   localparam logic [25:0] SA  = 26'h2340000;
   logic                 clk, rst_n, cmd_valid, cmd_ready, cmd_err, rd_valid, bypass;
   logic                 dq_oe, ce_n, we_n, oe_n, got_err;
   flash_host_pkg::cmd_t op;
   logic [25:0]          cmd_addr, pin_addr;
   logic [15:0]          cmd_data, rd_data, dq_out, m_dq, dq_w, got_rd;
   logic [4:0]           cmd_count;
   int                   err_count, samples_checked;
   assign dq_w = dq_oe ? dq_out : m_dq;
   flash_host_sequencer u_flash_host_sequencer (
      .I_CLK(clk), .I_RESET_N(rst_n), .I_CMD_VALID(cmd_valid), .I_CMD_OP(op),
      .I_CMD_ADDR(cmd_addr), .I_CMD_DATA(cmd_data), .I_CMD_COUNT(cmd_count),
      .O_CMD_READY(cmd_ready), .O_CMD_ERR(cmd_err), .O_RD_VALID(rd_valid),
      .O_RD_DATA(rd_data), .O_BYPASS(bypass), .O_ADDR(pin_addr), .O_DQ(dq_out),
      .O_DQ_OE(dq_oe), .I_DQ(dq_w), .O_CE_N(ce_n), .O_WE_N(we_n), .O_OE_N(oe_n));
   flash_dev_model #(.MFR_ID(MFR), .DEV_ID(DEV), .PROT(1'b1), .SEC_LCK(1'b1)) u_flash_dev_model (
      .i_addr(pin_addr), .i_dq(dq_w), .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n), .o_dq(m_dq));
   task automatic results();
      $display("mismatches %0d, comparisons %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic issue(input flash_host_pkg::cmd_t c, input logic [25:0] a,
                        input logic [15:0] d, input logic [4:0] n);
      int k;
      `CHK(u_flash_dev_model.wa.size(), 0)
      got_err = 1'b0;
      got_rd = 16'hXXXX;
      @(negedge clk);
      cmd_valid = 1'b1;
      op = c;
      cmd_addr = a;
      cmd_data = d;
      cmd_count = n;
      @(negedge clk);
      cmd_valid = 1'b0;
      for (k = 0; k < 300; k++) begin
         got_err |= cmd_err;
         if (rd_valid === 1'b1) got_rd = rd_data;
         if (k > 1 && cmd_ready === 1'b1) break;
         @(negedge clk);
      end
      if (k == 300) begin
         err_count++;
         results();
      end
   endtask
   task automatic wr(input logic [25:0] a, input logic [15:0] d);
      logic [25:0] ga;
      logic [15:0] gd;
      ga = u_flash_dev_model.wa.pop_front();
      gd = u_flash_dev_model.wd.pop_front();
      `CHK(ga, a)
      `CHK(gd, d)
   endtask
   task automatic u3(input logic [25:0] a, input logic [7:0] d);
      wr(26'h555, 16'h00AA);
      wr(26'h2AA, 16'h0055);
      wr(a, {8'h00, d});
   endtask
   task automatic t_program();
      `CHK({cmd_ready, ce_n, we_n, oe_n, dq_oe, bypass, cmd_err}, 7'b1111000)
      issue(flash_host_pkg::C_RESET, 26'h0, 16'h0, 5'h0);
      wr(26'h000, 16'h00F0);
      issue(flash_host_pkg::C_PROG, 26'h0000012, 16'hBEEF, 5'h0);
      u3(26'h555, 8'hA0);
      wr(26'h0000012, 16'hBEEF);
      issue(flash_host_pkg::C_READ, 26'h0000012, 16'h0, 5'h0);
      `CHK(got_rd, 16'hBEEF)
   endtask
   task automatic t_autosel();
      issue(flash_host_pkg::C_AUTOSEL, 26'h0, 16'h0, 5'h0);
      u3(26'h555, 8'h90);
      issue(flash_host_pkg::C_READ, 26'h0000000, 16'h0, 5'h0);
      `CHK(got_rd, MFR)
      issue(flash_host_pkg::C_READ, 26'h0000001, 16'h0, 5'h0);
      `CHK(got_rd, DEV + 16'h0001)
      issue(flash_host_pkg::C_READ, SA | 26'h2, 16'h0, 5'h0);
      `CHK(got_rd, 16'h0001)
      issue(flash_host_pkg::C_READ, 26'h0000003, 16'h0, 5'h0);
      `CHK(got_rd, 16'h0080)
      issue(flash_host_pkg::C_CFI, 26'h0, 16'h0, 5'h0);
      wr(26'h055, 16'h0098);
      issue(flash_host_pkg::C_RESET, 26'h0, 16'h0, 5'h0);
      wr(26'h000, 16'h00F0);
   endtask
   task automatic t_bypass();
      issue(flash_host_pkg::C_BYP_PROG, 26'h20, 16'h1111, 5'h0);
      `CHK(got_err, 1'b1)
      issue(flash_host_pkg::C_BYP_ENTER, 26'h0, 16'h0, 5'h0);
      u3(26'h555, 8'h20);
      `CHK(bypass, 1'b1)
      issue(flash_host_pkg::C_CFI, 26'h0, 16'h0, 5'h0);
      `CHK(got_err, 1'b1)
      issue(flash_host_pkg::C_BYP_PROG, 26'h20, 16'h1111, 5'h0);
      wr(26'h000, 16'h00A0);
      wr(26'h020, 16'h1111);
      issue(flash_host_pkg::C_READ, 26'h20, 16'h0, 5'h0);
      `CHK(got_rd, 16'h1111)
      issue(flash_host_pkg::C_BYP_SERASE, SEC, 16'h0, 5'h0);
      wr(26'h000, 16'h0080);
      wr(SA, 16'h0030);
      issue(flash_host_pkg::C_BYP_CERASE, 26'h0, 16'h0, 5'h0);
      wr(26'h000, 16'h0080);
      wr(26'h000, 16'h0010);
      issue(flash_host_pkg::C_BYP_EXIT, 26'h0, 16'h0, 5'h0);
      wr(26'h000, 16'h0090);
      wr(26'h000, 16'h0000);
      `CHK(bypass, 1'b0)
   endtask
   task automatic t_buffer();
      issue(flash_host_pkg::C_BUF_CONFIRM, SEC, 16'h0, 5'h0);
      `CHK(got_err, 1'b1)
      issue(flash_host_pkg::C_BUF_START, SEC, 16'h0, 5'h1);
      u3(SA, 8'h25);
      wr(SA, 16'h0001);
      issue(flash_host_pkg::C_BUF_WORD, 26'h2340040, 16'h0A0A, 5'h0);
      wr(26'h2340040, 16'h0A0A);
      issue(flash_host_pkg::C_BUF_WORD, 26'h2340060, 16'h0C0C, 5'h0);
      `CHK(got_err, 1'b1)
      issue(flash_host_pkg::C_BUF_CONFIRM, SEC, 16'h0, 5'h0);
      `CHK(got_err, 1'b1)
      issue(flash_host_pkg::C_BUF_WORD, 26'h234005F, 16'h0B0B, 5'h0);
      wr(26'h234005F, 16'h0B0B);
      issue(flash_host_pkg::C_BUF_WORD, 26'h2340041, 16'h0D0D, 5'h0);
      `CHK(got_err, 1'b1)
      issue(flash_host_pkg::C_BUF_CONFIRM, SEC, 16'h0, 5'h0);
      wr(SA, 16'h0029);
   endtask
   task automatic t_erase();
      issue(flash_host_pkg::C_CERASE, 26'h0, 16'h0, 5'h0);
      u3(26'h555, 8'h80);
      u3(26'h555, 8'h10);
      issue(flash_host_pkg::C_SERASE, SEC, 16'h0, 5'h0);
      u3(26'h555, 8'h80);
      u3(SA, 8'h30);
      issue(flash_host_pkg::C_SUSPEND, 26'h0, 16'h0, 5'h0);
      wr(26'h000, 16'h00B0);
      issue(flash_host_pkg::C_RESUME, 26'h0, 16'h0, 5'h0);
      wr(26'h000, 16'h0030);
      issue(flash_host_pkg::C_SEC_ENTRY, 26'h0, 16'h0, 5'h0);
      u3(26'h555, 8'h88);
      issue(flash_host_pkg::C_SEC_EXIT, 26'h0, 16'h0, 5'h0);
      u3(26'h555, 8'h90);
      wr(26'h000, 16'h0000);
      issue(flash_host_pkg::C_ABORT_RST, 26'h0, 16'h0, 5'h0);
      u3(26'h555, 8'hF0);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {rst_n, cmd_valid, cmd_addr, cmd_data, cmd_count, got_err, got_rd} = '0;
      op = flash_host_pkg::C_READ;
      err_count = 0;
      samples_checked = 0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      t_program();
      t_autosel();
      t_bypass();
      t_buffer();
      t_erase();
      results();
   end
endmodule
